// ---- scs_cmd_status.sv ----
// Purpose: Command-status timing of a serial-commanded speech playback device.
// Assumes: The playback datapath reports phrase starts, their rate and playing state.
// Notes:   All durations are counted in core_clk cycles.
//
// What this block does
// R1 - Quick power-up holds ready and busy low for 2.0 ms.
// R2 - Soft power-up holds ready and busy low for 66 ms.
// R3 - Quick power-down releases ready and busy within 6 us.
// R4 - Soft power-down holds ready and busy low for 64 ms.
// R5 - Ordinary commands pulse ready low for at most 6 us.
// R6 - Phrase byte of play holds ready low 4.125 ms at 4 kHz.
// R7 - That hold scales with the sampling rate of the last phrase.
// R8 - Reset sets the remembered sampling rate to 4 kHz.
// R9 - Ordinary commands other than loop set and clear pulse busy low at most 6 us when idle.
// R10 - Host spaces stop, loop and volume commands by at least 6 us.
// R11 - After loop set the next command is taken within 10 ms.
// R12 - Outputs update from the serial clock edge chosen by edge_select.
// R13 - Oscillator stays stopped from power-on until a power-up command.
// R14 - Data shifts MSB first; the eighth selected edge executes the command.
// R15 - Commands are bytes with opcode in upper nibble; play and silence take two.
// R16 - In reset and power down, ready and busy are high, audio grounded.
// R17 - Chip select high clears the bit counter, dropping partial bytes.
// R18 - Durations come from counting clock cycles.
`timescale 1ns/1ps
`include "scs_consts.svh"

module scs_cmd_status
#(
    parameter int QUICK_POWER_UP_CYC  = `SCS_QUICK_POWER_UP_US * `SCS_CLK_MHZ,
    parameter int SOFT_POWER_UP_CYC  = `SCS_SOFT_POWER_UP_US * `SCS_CLK_MHZ,
    parameter int SOFT_POWER_DOWN_CYC = `SCS_SOFT_POWER_DOWN_US * `SCS_CLK_MHZ,
    parameter int PLAY_CYC  = `SCS_PLAY_US_X1000 / 1000 * `SCS_CLK_MHZ
)
(
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire logic              clk_en,
    input  wire logic              chip_select_n,
    input  wire logic              serial_clock,
    input  wire logic              serial_data_in,
    input  wire logic              edge_select,
    input  wire logic              phrase_playing,
    input  wire logic              phrase_start,
    input  wire scs_pkg::scs_fs_type phrase_fs,
    output logic                   command_ready_n,
    output logic                   busy_n,
    output logic                   osc_enable,
    output logic                   analog_ground,
    output logic                   cmd_valid,
    output scs_pkg::scs_cmd_type   cmd_out
);
    import scs_pkg::*;

    localparam int TW        = `SCS_TIMER_W;
    localparam int SHORT_CYC = `SCS_SHORT_US * `SCS_CLK_MHZ;

    // Sampling rate times ten for each rate code.
    function automatic int fs_x10(input scs_fs_type fs);
        unique case (fs)
            SCS_FS_4K0:  fs_x10 = 40;
            SCS_FS_8K0:  fs_x10 = 80;
            SCS_FS_16K0: fs_x10 = 160;
            SCS_FS_5K3:  fs_x10 = 53;
            SCS_FS_10K7: fs_x10 = 107;
            SCS_FS_6K4:  fs_x10 = 64;
            SCS_FS_12K8: fs_x10 = 128;
            default:     fs_x10 = 40;
        endcase
    endfunction

    function automatic logic [TW-1:0] play_cycles(input scs_fs_type fs);
        play_cycles = TW'(PLAY_CYC * fs_x10(fs) / `SCS_BASE_FS_X10);   // R7
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    logic          byte_valid;
    logic [7:0]    byte_data;
    logic [3:0]    opcode;

    scs_serial_rx u_rx
    (
        .core_clk       (core_clk),
        .rstn           (rstn),
        .clk_en         (clk_en),
        .chip_select_n  (chip_select_n),
        .serial_clock   (serial_clock),
        .serial_data_in (serial_data_in),
        .edge_select    (edge_select),
        .byte_valid     (byte_valid),
        .byte_data      (byte_data)
    );

    assign opcode = byte_data[7:4];

    ////////////////////////////////////////////////////////////////////////////

    scs_state_type state_q;
    scs_fs_type    fs_q;
    logic [TW-1:0] timer_q;
    logic          ready_hold_q;
    logic          busy_hold_q;
    logic          second_q;
    logic [7:0]    first_q;
    logic          expired;

    assign expired = (ready_hold_q || busy_hold_q) && (timer_q == TW'(1));

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            fs_q <= SCS_FS_4K0;                                 // R8
        else if (clk_en && phrase_start)
            fs_q <= phrase_fs;                                  // R7
    end

    // Power state sequencing.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            state_q <= SCS_OFF;                                 // R13
        else if (clk_en)
        begin
            unique case (state_q)
                SCS_OFF:
                    if (byte_valid && !second_q &&
                        (opcode == `SCS_OP_QUICK_POWER_UP || opcode == `SCS_OP_SOFT_POWER_UP))
                        state_q <= SCS_UP_WAIT;
                SCS_UP_WAIT:
                    if (expired)
                        state_q <= SCS_READY;
                SCS_READY:
                    if (byte_valid && !second_q &&
                        (opcode == `SCS_OP_QUICK_POWER_DOWN || opcode == `SCS_OP_SOFT_POWER_DOWN))
                        state_q <= SCS_DOWN_WAIT;
                SCS_DOWN_WAIT:
                    if (expired)
                        state_q <= SCS_OFF;
                default:
                    state_q <= SCS_OFF;
            endcase
        end
    end

    // Handshake hold timer and the two hold flags.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            timer_q      <= '0;
            ready_hold_q <= 1'b0;
            busy_hold_q  <= 1'b0;
        end
        else if (clk_en)
        begin
            if (expired)
            begin
                ready_hold_q <= 1'b0;
                busy_hold_q  <= 1'b0;
                timer_q      <= '0;
            end
            else if (ready_hold_q || busy_hold_q)
                timer_q <= timer_q - TW'(1);                    // R18

            if (byte_valid && second_q && state_q == SCS_READY)
            begin
                ready_hold_q <= 1'b1;
                if (first_q[7:4] == `SCS_OP_PLAY)
                begin
                    timer_q     <= play_cycles(fs_q);           // R6
                    busy_hold_q <= 1'b0;
                end
                else
                begin
                    timer_q     <= TW'(SHORT_CYC);              // R5
                    busy_hold_q <= !phrase_playing;             // R9
                end
            end
            else if (byte_valid && state_q == SCS_OFF)
            begin
                if (opcode == `SCS_OP_QUICK_POWER_UP)
                begin
                    timer_q      <= TW'(QUICK_POWER_UP_CYC);              // R1
                    ready_hold_q <= 1'b1;
                    busy_hold_q  <= 1'b1;
                end
                else if (opcode == `SCS_OP_SOFT_POWER_UP)
                begin
                    timer_q      <= TW'(SOFT_POWER_UP_CYC);              // R2
                    ready_hold_q <= 1'b1;
                    busy_hold_q  <= 1'b1;
                end
            end
            else if (byte_valid && state_q == SCS_READY)
            begin
                ready_hold_q <= 1'b1;
                unique case (opcode)
                    `SCS_OP_QUICK_POWER_DOWN:
                    begin
                        timer_q     <= TW'(SHORT_CYC);          // R3
                        busy_hold_q <= 1'b1;
                    end
                    `SCS_OP_SOFT_POWER_DOWN:
                    begin
                        timer_q     <= TW'(SOFT_POWER_DOWN_CYC);          // R4
                        busy_hold_q <= 1'b1;
                    end
                    `SCS_OP_LOOP_SET, `SCS_OP_LOOP_CLR:
                    begin
                        timer_q     <= TW'(SHORT_CYC);          // R11
                        busy_hold_q <= 1'b0;
                    end
                    default:
                    begin
                        timer_q     <= TW'(SHORT_CYC);          // R5
                        busy_hold_q <= !phrase_playing;         // R9
                    end
                endcase
            end
        end
    end

    // Two-byte command tracking and the command output.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            second_q  <= 1'b0;
            first_q   <= 8'h00;
            cmd_valid <= 1'b0;
            cmd_out   <= '0;
        end
        else if (clk_en)
        begin
            cmd_valid <= 1'b0;
            if (byte_valid && state_q == SCS_READY)
            begin
                if (second_q)
                begin
                    second_q  <= 1'b0;                          // R15
                    cmd_valid <= 1'b1;
                    cmd_out   <= '{code: first_q, arg: byte_data, has_arg: 1'b1};
                end
                else if (opcode == `SCS_OP_PLAY || opcode == `SCS_OP_SILENCE)
                begin
                    second_q <= 1'b1;                           // R15
                    first_q  <= byte_data;
                end
                else
                begin
                    cmd_valid <= 1'b1;
                    cmd_out   <= '{code: byte_data, arg: 8'h00, has_arg: 1'b0};
                end
            end
            else if (state_q != SCS_READY)
                second_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Ready and busy stay high while powered down; only power-up commands are decoded then.
    assign command_ready_n = !ready_hold_q;                                      // R16
    assign busy_n          = !(busy_hold_q || (state_q == SCS_READY && phrase_playing));
    assign osc_enable      = (state_q != SCS_OFF);                               // R13
    assign analog_ground   = (state_q == SCS_OFF) || (state_q == SCS_UP_WAIT);   // R16

endmodule

// ---- scs_consts.svh ----
// Purpose: Shared constants for the speech command-status timing block.
// Assumes: A 40 MHz core clock stands in for the master clock.
// Notes:   Times are in microseconds; cycle counts are derived where used.
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

`define SCS_CLK_MHZ        40
`define SCS_QUICK_POWER_UP_US        2000
`define SCS_SOFT_POWER_UP_US        66000
`define SCS_SOFT_POWER_DOWN_US       64000
`define SCS_SHORT_US       6
`define SCS_PLAY_US_X1000  4125000
`define SCS_LOOP_MAX_US    10000
`define SCS_BASE_FS_X10    40

`define SCS_OP_QUICK_POWER_UP        4'h0
`define SCS_OP_SOFT_POWER_UP        4'h1
`define SCS_OP_QUICK_POWER_DOWN       4'h2
`define SCS_OP_SOFT_POWER_DOWN       4'h3
`define SCS_OP_PLAY        4'h4
`define SCS_OP_STOP        4'h6
`define SCS_OP_SILENCE     4'h7
`define SCS_OP_LOOP_SET    4'h8
`define SCS_OP_LOOP_CLR    4'h9
`define SCS_OP_VOLUME      4'ha

`define SCS_BITS_PER_CMD   8
`define SCS_TIMER_W        24

`endif

// ---- scs_pkg.sv ----
// Purpose: Types shared by the speech command-status timing block.
// Assumes: Constants come from scs_consts.svh.
// Notes:   Sampling rate codes follow the order of the supported rates.
package scs_pkg;

    typedef enum logic [3:0] {
        SCS_OFF       = 4'b0001,
        SCS_UP_WAIT   = 4'b0010,
        SCS_READY     = 4'b0100,
        SCS_DOWN_WAIT = 4'b1000
    } scs_state_type;

    typedef enum logic [2:0] {
        SCS_FS_4K0  = 3'h0,
        SCS_FS_8K0  = 3'h1,
        SCS_FS_16K0 = 3'h2,
        SCS_FS_5K3  = 3'h3,
        SCS_FS_10K7 = 3'h4,
        SCS_FS_6K4  = 3'h5,
        SCS_FS_12K8 = 3'h6
    } scs_fs_type;

    typedef struct packed {
        logic [7:0] code;
        logic [7:0] arg;
        logic       has_arg;
    } scs_cmd_type;

endpackage

// ---- scs_serial_rx.sv ----
// Purpose: Three-wire serial command receiver with pin synchronisers.
// Assumes: Pins are asynchronous to core_clk; serial clock is well below core_clk/4.
// Notes:   Emits one pulse per complete byte, MSB first.
`timescale 1ns/1ps
`include "scs_consts.svh"

module scs_serial_rx
(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       clk_en,
    input  wire logic       chip_select_n,
    input  wire logic       serial_clock,
    input  wire logic       serial_data_in,
    input  wire logic       edge_select,
    output logic            byte_valid,
    output logic [7:0]      byte_data
);
    import scs_pkg::*;

    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic       sck_prev_q;
    logic [2:0] count_q;
    logic [7:0] shift_q;
    logic       take;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_q <= 4'hf;
            sync2_q <= 4'hf;
        end
        else if (clk_en)
        begin
            sync1_q <= {chip_select_n, serial_clock, serial_data_in, edge_select};
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            sck_prev_q <= 1'b1;
        else if (clk_en)
            sck_prev_q <= sync2_q[2];
    end

    // Rising edge when edge_select is low, falling edge when it is high.
    assign take = !sync2_q[3] && (sync2_q[0] ? (sck_prev_q && !sync2_q[2])   // R12
                                             : (!sck_prev_q && sync2_q[2]));

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            count_q    <= 3'h0;
            shift_q    <= 8'h00;
            byte_valid <= 1'b0;
            byte_data  <= 8'h00;
        end
        else if (clk_en)
        begin
            byte_valid <= 1'b0;
            if (sync2_q[3])
                count_q <= 3'h0;                                // R17
            else if (take)
            begin
                shift_q <= {shift_q[6:0], sync2_q[1]};          // R14
                count_q <= count_q + 3'h1;
                if (count_q == 3'(`SCS_BITS_PER_CMD - 1))
                begin
                    byte_valid <= 1'b1;                         // R14
                    byte_data  <= {shift_q[6:0], sync2_q[1]};
                end
            end
        end
    end

endmodule

// ---- scs_host_model.sv ----
// Purpose: Host side of the three-wire serial command port.
// Assumes: Driven on falling core_clk edges; 200 ns serial half period.
// Notes:   Data shows the inverse of its last value while deselected.
`timescale 1ns/1ps
module scs_host_model
(
    input  wire logic core_clk,
    input  wire logic edge_select,
    output logic      chip_select_n,
    output logic      serial_clock,
    output logic      serial_data_in
);
    initial
    begin
        chip_select_n = 1'b1;
        serial_clock = 1'b0;
        serial_data_in = 1'b0;
    end
    task automatic half();
        repeat (8) @(negedge core_clk);
    endtask
    // Sends the top n bits of b, then deselects.
    task automatic send(input logic [7:0] b, input int n);
        serial_clock = edge_select;
        repeat (240) @(negedge core_clk);
        chip_select_n = 1'b0;
        half();
        for (int i = 7; i > 7 - n; i--)
        begin
            serial_data_in = b[i];
            half();
            serial_clock = ~edge_select;
            half();
            serial_clock = edge_select;
        end
        half();
        chip_select_n = 1'b1;
        serial_data_in = ~serial_data_in;
    endtask
endmodule

// ---- scs_cmd_status_chk.sv ----
// Purpose: Port checks of the command-status handshake timing.
// Assumes: Bound onto scs_cmd_status.
// Notes:   Hold lengths count the enabled cycles of the ready output.
`timescale 1ns/1ps
module scs_cmd_status_chk
#(
    parameter int QUICK_POWER_UP_CYC  = 400,
    parameter int SOFT_POWER_UP_CYC  = 800,
    parameter int SOFT_POWER_DOWN_CYC = 600
)
(
    input wire logic                 core_clk,
    input wire logic                 rstn,
    input wire logic                 clk_en,
    input wire logic                 phrase_playing,
    input wire logic                 command_ready_n,
    input wire logic                 busy_n,
    input wire logic                 osc_enable,
    input wire logic                 analog_ground,
    input wire logic                 cmd_valid,
    input wire scs_pkg::scs_cmd_type cmd_out
);
    import scs_pkg::*;
    logic [31:0] low_q;
    logic [3:0]  op_q;
    always_ff @(posedge core_clk or negedge rstn)
        if (!rstn)
            low_q <= '0;
        else if (command_ready_n)
            low_q <= '0;
        else if (clk_en)
            low_q <= low_q + 32'h1;
    always_ff @(posedge core_clk or negedge rstn)
        if (!rstn)
            op_q <= 4'hf;
        else if (!osc_enable)
            op_q <= 4'hf;
        else if (cmd_valid && clk_en)
            op_q <= cmd_out.code[7:4];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    short_hold_a: assert property ($rose(command_ready_n) && op_q inside
        {4'h2, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha} |-> low_q == 32'hf0) else $error("short hold");
    up_hold_a: assert property ($rose(command_ready_n) && $past(analog_ground)
        |-> low_q == QUICK_POWER_UP_CYC || low_q == SOFT_POWER_UP_CYC) else $error("power-up hold");
    down_hold_a: assert property ($rose(command_ready_n) && op_q == 4'h3
        |-> low_q == SOFT_POWER_DOWN_CYC) else $error("power-down hold");
    up_pair_a: assert property (osc_enable && analog_ground
        |-> busy_n == command_ready_n) else $error("busy apart from ready");
    off_high_a: assert property (!osc_enable && !$past(osc_enable)
        |-> command_ready_n && busy_n) else $error("outputs low while off");
    off_gnd_a: assert property (!osc_enable |-> analog_ground) else $error("audio live");
    osc_start_a: assert property ($rose(osc_enable)
        |-> !command_ready_n && !busy_n && analog_ground) else $error("bad start");
    valid_ready_a: assert property (cmd_valid |-> !command_ready_n) else $error("no strobe");
    play_busy_a: assert property (phrase_playing && command_ready_n && osc_enable
        && !analog_ground |-> !busy_n) else $error("busy high while playing");
    cover property ($rose(osc_enable));
    cover property ($fell(osc_enable));
    cover property (cmd_valid && cmd_out.has_arg);
endmodule

// ---- test_speech_cmd_status_timing.sv ----
// Purpose: Self-checking bench of the command-status handshake timing.
// Assumes: Shortened hold counts through the design parameters.
// Notes:   Low run lengths of ready and busy are measured in core_clk cycles.
`timescale 1ns/1ps
module test_speech_cmd_status_timing;
    import scs_pkg::*;
    localparam int QUICK_POWER_UP_CYC = 400;
    localparam int SOFT_POWER_UP_CYC = 800;
    localparam int SOFT_POWER_DOWN_CYC = 600;
    localparam int PLAY_CYC = 1000;
    logic        core_clk, rstn, clk_en, edge_select, phrase_playing, phrase_start;
    logic        chip_select_n, serial_clock, serial_data_in;
    logic        command_ready_n, busy_n, osc_enable, analog_ground, cmd_valid;
    scs_fs_type  phrase_fs;
    scs_cmd_type cmd_out, last_cmd;
    int          n_fail, n_tests, r_cnt, b_cnt, r_len, b_len, cyc;
    scs_cmd_status #(.QUICK_POWER_UP_CYC(QUICK_POWER_UP_CYC), .SOFT_POWER_UP_CYC(SOFT_POWER_UP_CYC), .SOFT_POWER_DOWN_CYC(SOFT_POWER_DOWN_CYC),
        .PLAY_CYC(PLAY_CYC)) dut (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
        .chip_select_n(chip_select_n), .serial_clock(serial_clock),
        .serial_data_in(serial_data_in), .edge_select(edge_select),
        .phrase_playing(phrase_playing), .phrase_start(phrase_start), .phrase_fs(phrase_fs),
        .command_ready_n(command_ready_n), .busy_n(busy_n), .osc_enable(osc_enable),
        .analog_ground(analog_ground), .cmd_valid(cmd_valid), .cmd_out(cmd_out));
    scs_host_model host (.core_clk(core_clk), .edge_select(edge_select),
        .chip_select_n(chip_select_n), .serial_clock(serial_clock),
        .serial_data_in(serial_data_in));
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cmd_valid === 1'b1)
            last_cmd = cmd_out;
        if (command_ready_n === 1'b0)
            r_cnt++;
        else if (r_cnt > 0)
            {r_len, r_cnt} = {r_cnt, 32'h0};
        if (busy_n === 1'b0)
            b_cnt++;
        else if (b_cnt > 0)
            {b_len, b_cnt} = {b_cnt, 32'h0};
        if (cyc > 40000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (n_fail == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask
    // Sends a byte and waits until the ready strobe is released.
    task automatic cmd(input logic [7:0] b, input int n = 8, input int frz = 0);
        r_len = 0;
        b_len = 0;
        last_cmd = '0;
        host.send(b, n);
        // Optionally freezes the block while the hold runs.
        if (frz > 0)
        begin
            clk_en = 1'b0;
            repeat (frz) @(negedge core_clk);
            clk_en = 1'b1;
        end
        for (int i = 0; i < 3000 && (r_cnt != 0 || command_ready_n !== 1'b1); i++)
            @(negedge core_clk);
        repeat (2) @(negedge core_clk);
    endtask
    task automatic t_off();
        chk({command_ready_n, busy_n, osc_enable, analog_ground}, 4'hd);
        cmd(8'ha5);
        chk(r_len, 0);
        chk(osc_enable, 1'h0);
    endtask
    task automatic t_quick_power_up();
        cmd(8'h00);
        chk(r_len, QUICK_POWER_UP_CYC);
        chk(b_len, QUICK_POWER_UP_CYC);
        chk({osc_enable, analog_ground}, 2'h2);
    endtask
    task automatic t_vol_falling();
        edge_select = 1'b1;
        cmd(8'ha5);
        chk(r_len, 240);
        chk(b_len, 240);
        chk(last_cmd, {8'ha5, 8'h00, 1'h0});
    endtask
    task automatic t_freeze();
        cmd(8'ha6, 8, 50);
        chk(r_len, 290);
        chk(b_len, 290);
    endtask
    task automatic t_partial();
        cmd(8'hff, 3);
        chk(r_len, 0);
        cmd(8'h90);
        chk(last_cmd, {8'h90, 8'h00, 1'h0});
    endtask
    task automatic t_play();
        edge_select = 1'b0;
        cmd(8'h40);
        cmd(8'h12);
        chk(r_len, PLAY_CYC);
        chk(last_cmd, {8'h40, 8'h12, 1'h1});
        phrase_start = 1'b1;
        phrase_fs = SCS_FS_8K0;
        phrase_playing = 1'b1;
        @(negedge core_clk);
        phrase_start = 1'b0;
        cmd(8'h40);
        cmd(8'h34);
        chk(r_len, PLAY_CYC * 2);
        cmd(8'h80);
        chk(r_len, 240);
        phrase_playing = 1'b0;
        cmd(8'h60);
        chk(r_len, 240);
        chk(b_len, 240);
    endtask
    // Resets in mid-run while a hold is active, then powers up and plays again.
    task automatic t_reset();
        host.send(8'ha5, 8);
        rstn = 1'b0;
        @(negedge core_clk);
        chk({command_ready_n, busy_n, osc_enable, analog_ground}, 4'hd);
        repeat (5) @(negedge core_clk);
        rstn = 1'b1;
        @(negedge core_clk);
        cmd(8'h00);
        chk(r_len, QUICK_POWER_UP_CYC);
        cmd(8'h40);
        cmd(8'h12);
        chk(r_len, PLAY_CYC);
    endtask
    task automatic t_power();
        cmd(8'h20);
        chk(r_len, 240);
        chk(b_len, 240);
        chk({osc_enable, analog_ground}, 2'h1);
        cmd(8'h10);
        chk(r_len, SOFT_POWER_UP_CYC);
        chk(b_len, SOFT_POWER_UP_CYC);
        cmd(8'h30);
        chk(r_len, SOFT_POWER_DOWN_CYC);
        chk(b_len, SOFT_POWER_DOWN_CYC);
        chk(osc_enable, 1'h0);
    endtask
    initial
    begin
        rstn = 1'b0;
        clk_en = 1'b1;
        edge_select = 1'b0;
        phrase_playing = 1'b0;
        phrase_start = 1'b0;
        phrase_fs = SCS_FS_4K0;
        repeat (6) @(negedge core_clk);
        rstn = 1'b1;
        @(negedge core_clk);
        t_off();
        t_quick_power_up();
        t_vol_falling();
        t_freeze();
        t_partial();
        t_play();
        t_reset();
        t_power();
        tally_and_finish();
    end
endmodule
bind scs_cmd_status scs_cmd_status_chk #(.QUICK_POWER_UP_CYC(QUICK_POWER_UP_CYC), .SOFT_POWER_UP_CYC(SOFT_POWER_UP_CYC),
    .SOFT_POWER_DOWN_CYC(SOFT_POWER_DOWN_CYC)) u_chk (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
    .phrase_playing(phrase_playing), .command_ready_n(command_ready_n), .busy_n(busy_n),
    .osc_enable(osc_enable), .analog_ground(analog_ground), .cmd_valid(cmd_valid),
    .cmd_out(cmd_out));
